// ==== dv/pisd_vco_model.sv ====
// behavioural oscillator that feeds the two divider inputs
`timescale 1ns/1ns
module pisd_vco_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic high_band_pulldown,
    input wire logic low_band_pulldown,
    input wire logic phase_error_out_a,
    input wire logic phase_error_out_b,
    output logic high_band_input,
    output logic low_band_input
);
    logic osc;
    int cnt;
    // error outputs only nudge the rate, a real loop filter would be slower
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc <= 1'b0;
            cnt <= 0;
        end else if (cnt >= (phase_error_out_a ? 1 : (phase_error_out_b ? 3 : 2))) begin
            osc <= ~osc;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // a pulled-down pin sits at the pulled level, not at the oscillator
    assign high_band_input = high_band_pulldown ? 1'b0 : osc;
    assign low_band_input = low_band_pulldown ? 1'b0 : osc;
endmodule // pisd_vco_model

// ==== dv/tb_pll_input_select_divider_mode.sv ====
// self-checking bench for the input select and divider mode block
`timescale 1ns/1ns
module tb_pll_input_select_divider_mode;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tuner_enable, watchdog_stack_reset, clock_stop, err;
    logic high_band_input, low_band_input, high_band_pulldown, low_band_pulldown;
    logic phase_error_out_a, phase_error_out_b, lsb;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed;
    pisd_top #(.REF_BASE_CYCLES(2), .MODULUS(32)) pisd_top_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tuner_enable(tuner_enable), .watchdog_stack_reset(watchdog_stack_reset),
        .clock_stop(clock_stop), .high_band_input(high_band_input),
        .low_band_input(low_band_input), .high_band_pulldown(high_band_pulldown),
        .low_band_pulldown(low_band_pulldown), .phase_error_out_a(phase_error_out_a),
        .phase_error_out_b(phase_error_out_b), .irq(irq));
    pisd_vco_model pisd_vco_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .high_band_pulldown(high_band_pulldown), .low_band_pulldown(low_band_pulldown),
        .phase_error_out_a(phase_error_out_a), .phase_error_out_b(phase_error_out_b),
        .high_band_input(high_band_input), .low_band_input(low_band_input));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task complete_run;
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // pulldown pair {high, low} expected for a mode code
    function automatic logic [1:0] exp_pd(input logic [1:0] m);
        case (m)
            2'b01: exp_pd = 2'b10;
            2'b10: exp_pd = 2'b01;
            2'b11: exp_pd = 2'b10;
            default: exp_pd = 2'b11;
        endcase
    endfunction
    task chk_pd(input logic [1:0] m);
        repeat (3) @(posedge clk_sys);
        chk("pulldowns", {30'h0, exp_pd(m)}, {30'h0, high_band_pulldown, low_band_pulldown});
    endtask
    // raise one clear source with mode 11 and lsb set, mode must drop, lsb must stay
    task clear_src(input int which);
        apb(1'b1, pisd_pkg::ADDR_MODE, 32'hb);
        @(posedge clk_sys);
        tuner_enable <= (which != 0);
        watchdog_stack_reset <= (which == 1);
        clock_stop <= (which == 2);
        apb(1'b0, pisd_pkg::ADDR_MODE, 32'h0);
        chk("mode cleared", 32'h8, rd);
        chk_pd(2'b00);
        if (which == 0) begin
            chk("error outs", 32'h0, {30'h0, phase_error_out_a, phase_error_out_b});
        end
        tuner_enable <= 1'b1;
        watchdog_stack_reset <= 1'b0;
        clock_stop <= 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, watchdog_stack_reset, clock_stop} = 5'h0;
        tuner_enable = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        seed = $urandom(32'hc744);
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, pisd_pkg::ADDR_MODE, 32'h0);
        chk("mode reset", 32'h0, rd);
        chk_pd(2'b00);
        apb(1'b0, pisd_pkg::ADDR_REF_SEL, 32'h0);
        chk("ref_sel reset", 32'h0, rd);
        apb(1'b1, pisd_pkg::ADDR_REF_SEL, 32'hffff_fff5);
        apb(1'b0, pisd_pkg::ADDR_REF_SEL, 32'h0);
        chk("ref_sel", 32'h5, rd);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        // each mode with a random swallow lsb; bit 2 always reads 0
        for (int m = 0; m < 4; m++) begin
            lsb = $urandom_range(1, 0);
            apb(1'b1, pisd_pkg::ADDR_MODE, {$urandom} & 32'hffff_fff0 | {lsb, 1'b1, m[1:0]});
            apb(1'b0, pisd_pkg::ADDR_MODE, 32'h0);
            chk("mode", {28'h0, lsb, 1'b0, m[1:0]}, rd);
            chk_pd(m[1:0]);
        end
        for (int s = 0; s < 3; s++) clear_src(s);
        // divided pulses land in irq status bit 1, seen on irq through the mask
        apb(1'b1, pisd_pkg::ADDR_DATA_BUF, 32'h0040);
        apb(1'b1, pisd_pkg::ADDR_DIV_VALUE, 32'h0);
        apb(1'b0, pisd_pkg::ADDR_DIV_VALUE, 32'h0);
        chk("divider value", 32'h0040, rd);
        apb(1'b1, pisd_pkg::ADDR_IRQ_MASK, 32'h2);
        for (int m = 3; m >= 0; m--) begin
            apb(1'b1, pisd_pkg::ADDR_MODE, {28'h0, 1'b1, 1'b0, m[1:0]});
            apb(1'b0, pisd_pkg::ADDR_IRQ_STAT, 32'h0);
            repeat (900) @(posedge clk_sys);
            chk("div irq", {31'h0, m != 0}, {31'h0, irq});
            // with no divided pulses the reference keeps leading, so only the raise output stands
            if (m == 0) begin
                chk("lead", 32'h2, {30'h0, phase_error_out_a, phase_error_out_b});
            end
            apb(1'b0, pisd_pkg::ADDR_IRQ_STAT, 32'h0);
            chk("div stat", {30'h0, m != 0, 1'b0}, rd & 32'h2);
        end
        apb(1'b1, pisd_pkg::ADDR_MODE, 32'h1);
        apb(1'b1, pisd_pkg::ADDR_IRQ_MASK, 32'h0);
        repeat (100) @(posedge clk_sys);
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b0, pisd_pkg::ADDR_UNLOCK, 32'h0);
        // repeated reference ticks in mode 00 are cycle slips, so the sticky flag must be set
        chk("unlock", 32'h1, rd);
        complete_run();
    end
endmodule // tb_pll_input_select_divider_mode

// ==== hw/pisd_divider.sv ====
// programmable divider: swallow counter, programmable counter, prescaler
`timescale 1ns/1ns
module pisd_divider #(
    parameter int SWALLOW_W = pisd_pkg::SWALLOW_W,
    parameter int PROG_W = pisd_pkg::PROG_W,
    parameter int MODULUS = pisd_pkg::PRESCALE_MODULUS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic swallow_mode,
    input wire logic in_edge,
    input wire logic [SWALLOW_W+PROG_W-1:0] n_value,
    output logic div_pulse
);
    localparam int PRE_W = $clog2(MODULUS + 1);
    localparam logic [PRE_W-1:0] PRE_LONG = PRE_W'(MODULUS);
    localparam logic [PRE_W-1:0] PRE_SHORT = PRE_W'(MODULUS - 1);

    // swallow values must stay below the prescaler ratio or n is not monotonic
    if (MODULUS < (2 ** SWALLOW_W) || SWALLOW_W < 1 || PROG_W < 2) begin : g_bad
        $error("pisd_divider: unsupported width or modulus");
    end

    logic [PRE_W-1:0] pre;
    logic [SWALLOW_W-1:0] swc;
    logic [PROG_W-1:0] pgc;
    logic [PRE_W-1:0] next_pre;
    logic [SWALLOW_W-1:0] next_swc;
    logic [PROG_W-1:0] next_pgc;
    logic next_pulse;
    logic [SWALLOW_W-1:0] load_a;
    logic [PROG_W-1:0] load_b;
    logic last;

    assign load_a = n_value[SWALLOW_W-1:0];
    assign load_b = n_value[SWALLOW_W+PROG_W-1:SWALLOW_W];
    assign last = (pgc <= PROG_W'(1));

    always_comb begin
        next_pre = pre;
        next_swc = swc;
        next_pgc = pgc;
        next_pulse = 1'b0;
        if (!run) begin
            next_swc = load_a;
            next_pgc = load_b;
            next_pre = (load_a != '0) ? PRE_LONG : PRE_SHORT;
        end else if (in_edge) begin
            if (!swallow_mode) begin
                // programmable counter alone divides by load_b
                if (last) begin
                    next_pulse = 1'b1;
                    next_pgc = load_b;
                end else begin
                    next_pgc = pgc - PROG_W'(1);
                end
            end else if (pre == '0) begin
                // prescaler period ends: m+1 while swallowing, m after
                if (last) begin
                    next_pulse = 1'b1;
                    next_pgc = load_b;
                    next_swc = load_a;
                    next_pre = (load_a != '0) ? PRE_LONG : PRE_SHORT;
                end else begin
                    next_pgc = pgc - PROG_W'(1);
                    next_swc = (swc != '0) ? swc - SWALLOW_W'(1) : swc;
                    next_pre = (swc > SWALLOW_W'(1)) ? PRE_LONG : PRE_SHORT;
                end
            end else begin
                next_pre = pre - PRE_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre <= '0;
            swc <= '0;
            pgc <= '0;
            div_pulse <= 1'b0;
        end else begin
            pre <= next_pre;
            swc <= next_swc;
            pgc <= next_pgc;
            div_pulse <= next_pulse;
        end
    end
endmodule // pisd_divider

// ==== hw/pisd_top.sv ====
// input selection, division mode control and phase compare with apb registers
//
// Overview of operation
// - The synthesizer runs only while tuner_enable is high and is held disabled while it is low.
// - Mode register bits 1 and 0 select the division mode.
// - Mode 00 disables both inputs, 01 direct on low band, 10 swallow high band, 11 swallow low.
// - Mode register bit 3 supplies the least significant bit of the swallow counter value.
// - Writing 0 or 1 to that bit makes the swallow counter lowest bit 0 or 1.
// - The input that the current mode does not select is pulled down.
// - Direct division uses only the programmable counter, not the swallow counter.
// - The divider divides the selected input by the swallow and programmable counter values.
// - Resets and clock stop clear the mode field; only power-on reset (rst_n) may lose the lsb.
// - A four-bit field selects the reference frequency for phase comparison.
// - Bit 0 of the unlock register reflects the unlock flip-flop.
// - The phase difference of divided input and reference appears on the two error outputs.
// - Both swallow modes use the swallow and programmable counters together.
// - The divider is a 5-bit swallow and a 12-bit programmable down counter.
// - With mode 00 the inputs are pulled down and the divider is held loaded; reference and phase compare keep running.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module pisd_top #(
    parameter int REF_BASE_CYCLES = pisd_pkg::REF_BASE_CYCLES,
    parameter int MODULUS = pisd_pkg::PRESCALE_MODULUS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tuner_enable,
    input wire logic watchdog_stack_reset,
    input wire logic clock_stop,
    input wire logic high_band_input,
    input wire logic low_band_input,
    output logic high_band_pulldown,
    output logic low_band_pulldown,
    output logic phase_error_out_a,
    output logic phase_error_out_b,
    output logic irq
);
    localparam int MAX_REF_CYCLES = (2 ** pisd_pkg::REF_SEL_W) * REF_BASE_CYCLES;

    if (REF_BASE_CYCLES < 1 || MAX_REF_CYCLES > (2 ** pisd_pkg::REF_CNT_W)) begin : g_bad
        $error("pisd_top: reference step does not fit the counter");
    end

    // register state
    pisd_pkg::pisd_mode_t mode;
    pisd_pkg::pisd_mode_t next_mode;
    logic swlsb;
    logic next_swlsb;
    logic [pisd_pkg::DIV_REG_W-1:0] data_buf;
    logic [pisd_pkg::DIV_REG_W-1:0] next_data_buf;
    logic [pisd_pkg::DIV_REG_W-1:0] div_value;
    logic [pisd_pkg::DIV_REG_W-1:0] next_div_value;
    logic [pisd_pkg::REF_SEL_W-1:0] ref_sel;
    logic [pisd_pkg::REF_SEL_W-1:0] next_ref_sel;
    logic [pisd_pkg::IRQ_W-1:0] irq_mask;
    logic [pisd_pkg::IRQ_W-1:0] next_irq_mask;
    logic [pisd_pkg::IRQ_W-1:0] irq_stat;
    logic [pisd_pkg::IRQ_W-1:0] next_irq_stat;
    logic unlock_flag;
    logic next_unlock_flag;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] rd_word;
    logic rd_hit;

    // input stage, reference and phase compare state
    logic low_prev;
    logic high_prev;
    logic next_high_pulldown;
    logic next_low_pulldown;
    logic in_edge;
    logic [pisd_pkg::REF_CNT_W-1:0] ref_cnt;
    logic [pisd_pkg::REF_CNT_W-1:0] next_ref_cnt;
    logic [pisd_pkg::REF_CNT_W-1:0] ref_period;
    logic ref_tick;
    logic next_ref_tick;
    pisd_pkg::pisd_pfd_t pfd;
    pisd_pkg::pisd_pfd_t next_pfd;
    logic unlock_ev;
    logic div_pulse;
    logic div_run;
    logic swallow_mode;
    logic [pisd_pkg::IRQ_W-1:0] events;

    logic setup_phase;
    logic access_wr;
    logic access_rd;
    logic hold_clear;

    assign setup_phase = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign access_rd = psel && penable && !pwrite;
    // every access completes in its first access cycle
    assign pready = 1'b1;
    assign hold_clear = !tuner_enable || watchdog_stack_reset || clock_stop;

    // register writes and the forced mode clear
    always_comb begin
        next_mode = mode;
        next_swlsb = swlsb;
        next_data_buf = data_buf;
        next_div_value = div_value;
        next_ref_sel = ref_sel;
        next_irq_mask = irq_mask;
        if (access_wr) begin
            if (paddr == pisd_pkg::ADDR_MODE) begin
                next_mode = pisd_pkg::pisd_mode_t'(pwdata[pisd_pkg::MODE_LO_BIT +: pisd_pkg::MODE_W]);
                next_swlsb = pwdata[pisd_pkg::SWLSB_BIT];
            end else if (paddr == pisd_pkg::ADDR_DATA_BUF) begin
                next_data_buf = pwdata[pisd_pkg::DIV_REG_W-1:0];
            end else if (paddr == pisd_pkg::ADDR_DIV_VALUE) begin
                // the written word is ignored: the buffer is what gets loaded
                next_div_value = data_buf;
            end else if (paddr == pisd_pkg::ADDR_REF_SEL) begin
                next_ref_sel = pwdata[pisd_pkg::REF_SEL_W-1:0];
            end else if (paddr == pisd_pkg::ADDR_IRQ_MASK) begin
                next_irq_mask = pwdata[pisd_pkg::IRQ_W-1:0];
            end
        end
        // a clear beats a write in the same cycle; the lsb survives
        if (hold_clear) begin
            next_mode = pisd_pkg::PISD_MODE_OFF;
        end
    end

    // read data is captured in the setup cycle so it stands for the whole access
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (paddr == pisd_pkg::ADDR_MODE) begin
            rd_word[pisd_pkg::MODE_LO_BIT +: pisd_pkg::MODE_W] = mode;
            rd_word[pisd_pkg::SWLSB_BIT] = swlsb;
        end else if (paddr == pisd_pkg::ADDR_DATA_BUF) begin
            rd_word[pisd_pkg::DIV_REG_W-1:0] = data_buf;
        end else if (paddr == pisd_pkg::ADDR_DIV_VALUE) begin
            rd_word[pisd_pkg::DIV_REG_W-1:0] = div_value;
        end else if (paddr == pisd_pkg::ADDR_REF_SEL) begin
            rd_word[pisd_pkg::REF_SEL_W-1:0] = ref_sel;
        end else if (paddr == pisd_pkg::ADDR_UNLOCK) begin
            rd_word[pisd_pkg::UNLOCK_BIT] = unlock_flag;
        end else if (paddr == pisd_pkg::ADDR_IRQ_STAT) begin
            rd_word[pisd_pkg::IRQ_W-1:0] = irq_stat;
        end else if (paddr == pisd_pkg::ADDR_IRQ_MASK) begin
            rd_word[pisd_pkg::IRQ_W-1:0] = irq_mask;
        end else begin
            rd_hit = 1'b0;
        end
        next_prdata = setup_phase ? rd_word : prdata;
        next_pslverr = setup_phase ? !rd_hit : pslverr;
    end

    // sticky flags: a read clears only the bits it returned, so an event
    // landing between setup and access is never lost
    assign events[pisd_pkg::IRQ_UNLOCK_BIT] = unlock_ev;
    assign events[pisd_pkg::IRQ_DIVOUT_BIT] = div_pulse;

    always_comb begin
        next_irq_stat = irq_stat;
        next_unlock_flag = unlock_flag;
        if (access_rd && paddr == pisd_pkg::ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~prdata[pisd_pkg::IRQ_W-1:0];
        end
        if (access_rd && paddr == pisd_pkg::ADDR_UNLOCK && prdata[pisd_pkg::UNLOCK_BIT]) begin
            next_unlock_flag = 1'b0;
        end
        next_irq_stat = next_irq_stat | events;
        if (unlock_ev) begin
            next_unlock_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode <= pisd_pkg::PISD_MODE_OFF;
            swlsb <= pisd_pkg::SWLSB_RST;
            data_buf <= pisd_pkg::DIV_REG_RST;
            div_value <= pisd_pkg::DIV_REG_RST;
            ref_sel <= pisd_pkg::REF_SEL_RST;
            irq_mask <= pisd_pkg::IRQ_MASK_RST;
            irq_stat <= '0;
            unlock_flag <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            mode <= next_mode;
            swlsb <= next_swlsb;
            data_buf <= next_data_buf;
            div_value <= next_div_value;
            ref_sel <= next_ref_sel;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            unlock_flag <= next_unlock_flag;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // input selection: mode 00 only parks the pins, the reference keeps running
    always_comb begin
        in_edge = 1'b0;
        next_high_pulldown = 1'b1;
        next_low_pulldown = 1'b1;
        case (mode)
            pisd_pkg::PISD_MODE_DIRECT, pisd_pkg::PISD_MODE_SW_LOW: begin
                in_edge = low_band_input && !low_prev;
                next_low_pulldown = 1'b0;
            end
            pisd_pkg::PISD_MODE_SW_HIGH: begin
                in_edge = high_band_input && !high_prev;
                next_high_pulldown = 1'b0;
            end
            default: begin
                in_edge = 1'b0;
            end
        endcase
        if (hold_clear) begin
            next_high_pulldown = 1'b1;
            next_low_pulldown = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_prev <= 1'b0;
            high_prev <= 1'b0;
            high_band_pulldown <= 1'b1;
            low_band_pulldown <= 1'b1;
        end else begin
            low_prev <= low_band_input;
            high_prev <= high_band_input;
            high_band_pulldown <= next_high_pulldown;
            low_band_pulldown <= next_low_pulldown;
        end
    end

    assign div_run = tuner_enable && (mode != pisd_pkg::PISD_MODE_OFF);
    assign swallow_mode = (mode == pisd_pkg::PISD_MODE_SW_HIGH)
        || (mode == pisd_pkg::PISD_MODE_SW_LOW);

    pisd_divider #(
        .SWALLOW_W(pisd_pkg::SWALLOW_W),
        .PROG_W(pisd_pkg::PROG_W),
        .MODULUS(MODULUS)
    ) u_divider (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(div_run),
        .swallow_mode(swallow_mode),
        .in_edge(in_edge),
        .n_value({div_value, swlsb}),
        .div_pulse(div_pulse)
    );

    // reference divider: period is (code + 1) reference steps
    assign ref_period = pisd_pkg::REF_CNT_W'((32'(ref_sel) + 1) * REF_BASE_CYCLES - 1);

    always_comb begin
        next_ref_cnt = ref_cnt;
        next_ref_tick = 1'b0;
        if (!tuner_enable) begin
            next_ref_cnt = ref_period;
        end else if (ref_cnt == '0) begin
            next_ref_tick = 1'b1;
            next_ref_cnt = ref_period;
        end else begin
            next_ref_cnt = ref_cnt - pisd_pkg::REF_CNT_W'(1);
        end
    end

    // phase compare: a second edge on the same side before the other
    // arrives is a cycle slip and marks the loop unlocked
    always_comb begin
        next_pfd = pfd;
        unlock_ev = 1'b0;
        case (pfd)
            pisd_pkg::PISD_PFD_IDLE: begin
                if (ref_tick && !div_pulse) begin
                    next_pfd = pisd_pkg::PISD_PFD_UP;
                end else if (div_pulse && !ref_tick) begin
                    next_pfd = pisd_pkg::PISD_PFD_DOWN;
                end
            end
            pisd_pkg::PISD_PFD_UP: begin
                if (div_pulse) begin
                    next_pfd = pisd_pkg::PISD_PFD_IDLE;
                end else if (ref_tick) begin
                    unlock_ev = 1'b1;
                end
            end
            pisd_pkg::PISD_PFD_DOWN: begin
                if (ref_tick) begin
                    next_pfd = pisd_pkg::PISD_PFD_IDLE;
                end else if (div_pulse) begin
                    unlock_ev = 1'b1;
                end
            end
            default: begin
                next_pfd = pisd_pkg::PISD_PFD_IDLE;
            end
        endcase
        if (!tuner_enable) begin
            next_pfd = pisd_pkg::PISD_PFD_IDLE;
            unlock_ev = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt <= '0;
            ref_tick <= 1'b0;
            pfd <= pisd_pkg::PISD_PFD_IDLE;
        end else begin
            ref_cnt <= next_ref_cnt;
            ref_tick <= next_ref_tick;
            pfd <= next_pfd;
        end
    end

    assign phase_error_out_a = (pfd == pisd_pkg::PISD_PFD_UP);
    assign phase_error_out_b = (pfd == pisd_pkg::PISD_PFD_DOWN);

    disabled_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !tuner_enable |=> high_band_pulldown && low_band_pulldown
            && mode == pisd_pkg::PISD_MODE_OFF && !phase_error_out_a)
        else $error("disabled block still active");

    mode_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        access_wr && paddr == pisd_pkg::ADDR_MODE && !hold_clear
        |=> mode == $past(pwdata[pisd_pkg::MODE_LO_BIT +: pisd_pkg::MODE_W]))
        else $error("mode field not written");

    high_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pisd_pkg::PISD_MODE_SW_HIGH && !hold_clear
        |=> !high_band_pulldown && low_band_pulldown)
        else $error("high band selection wrong");

    low_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == pisd_pkg::PISD_MODE_DIRECT || mode == pisd_pkg::PISD_MODE_SW_LOW) && !hold_clear
        |=> !low_band_pulldown && high_band_pulldown)
        else $error("low band selection wrong");

    lsb_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        access_wr && paddr == pisd_pkg::ADDR_MODE |=> swlsb == $past(pwdata[pisd_pkg::SWLSB_BIT]))
        else $error("swallow lsb not written");

    clear_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hold_clear && !(access_wr && paddr == pisd_pkg::ADDR_MODE)
        |=> mode == pisd_pkg::PISD_MODE_OFF && $stable(swlsb))
        else $error("mode clear wrong");

    unlock_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unlock_ev |=> unlock_flag && irq_stat[pisd_pkg::IRQ_UNLOCK_BIT])
        else $error("unlock not latched");

    phase_lead_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tuner_enable && pfd == pisd_pkg::PISD_PFD_IDLE && ref_tick && !div_pulse
        |=> phase_error_out_a && !phase_error_out_b)
        else $error("reference lead not shown");

    divout_event_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        div_pulse |=> irq_stat[1] ##0 (irq_mask[1] -> irq))
        else $error("divided pulse lost");

    transfer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        access_wr && paddr == pisd_pkg::ADDR_DIV_VALUE |=> div_value == $past(data_buf))
        else $error("buffer transfer failed");
endmodule // pisd_top

// ==== inc/pisd_pkg.sv ====
// shared constants and types for the input select / divider mode block
package pisd_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_DATA_BUF = 8'h04;
    localparam logic [7:0] ADDR_DIV_VALUE = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_REF_SEL = 8'h14;
    localparam logic [7:0] ADDR_UNLOCK = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

    // mode register fields
    localparam int MODE_LO_BIT = 0;
    localparam int MODE_W = 2;
    localparam int SWLSB_BIT = 3;

    // other field layouts
    localparam int REF_SEL_W = 4;
    localparam int DIV_REG_W = 16;
    localparam int SWALLOW_W = 5;
    localparam int PROG_W = 12;
    localparam int N_W = SWALLOW_W + PROG_W;
    localparam int UNLOCK_BIT = 0;
    localparam int IRQ_W = 2;
    localparam int IRQ_UNLOCK_BIT = 0;
    localparam int IRQ_DIVOUT_BIT = 1;
    localparam int REF_CNT_W = 16;

    // reset values
    localparam logic SWLSB_RST = 1'b0;
    localparam logic [DIV_REG_W-1:0] DIV_REG_RST = 16'h0000;
    localparam logic [REF_SEL_W-1:0] REF_SEL_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // timing: one reference step, scaled by the select code
    localparam int CLK_PERIOD_NS = 100;
    localparam int REF_STEP_NS = 1000;
    localparam int REF_BASE_CYCLES = (REF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // dual modulus prescaler ratio in swallow modes
    localparam int PRESCALE_MODULUS = 32;

    typedef enum logic [1:0] {
        PISD_MODE_OFF = 2'b00,
        PISD_MODE_DIRECT = 2'b01,
        PISD_MODE_SW_HIGH = 2'b10,
        PISD_MODE_SW_LOW = 2'b11
    } pisd_mode_t;

    typedef enum logic [1:0] {
        PISD_PFD_IDLE = 2'b00,
        PISD_PFD_UP = 2'b01,
        PISD_PFD_DOWN = 2'b10
    } pisd_pfd_t;
endpackage
